// File: verification/cbls_exec_tb_top.sv
// Self-checking bench for the branch and data-transfer execution unit.
`timescale 1ns/1ps
`include "cbls_consts.svh"
module cbls_exec_tb_top import cbls_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] dmem_addr;
  logic [15:0] pmem_addr;
  logic [7:0]  dmem_wdata;
  logic [7:0]  dmem_rdata;
  logic [7:0]  pmem_rdata;
  logic        dmem_rd;
  logic        dmem_wr;
  logic        pmem_rd;
  logic        busy;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;

  cbls_exec i_cbls_exec (.sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .dmem_addr, .dmem_wdata, .dmem_rd,
    .dmem_wr, .dmem_rdata, .pmem_addr, .pmem_rd, .pmem_rdata, .busy);
  cbls_mem_model i_cbls_mem_model (.sys_clk, .dmem_addr, .dmem_wdata, .dmem_rd, .dmem_wr,
    .dmem_rdata, .pmem_addr, .pmem_rd, .pmem_rdata);

  always #2 sys_clk = ~sys_clk;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // The whole sequence needs well under 10000 cycles; this ceiling only catches a hang.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One idle edge after each release keeps a following request from reassigning in one step.
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read    <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask : bus_rd

  task automatic rgpr(input int n, output logic [31:0] d);
    bus_rd(8'(`CBLS_REG_GPR + n * 4), d);
  endtask : rgpr

  task automatic wgpr(input int n, input logic [7:0] v);
    bus_wr(8'(`CBLS_REG_GPR + n * 4), {24'h0, v});
  endtask : wgpr

  task automatic wptr(input int p, input logic [15:0] v);
    wgpr(26 + 2 * p, v[7:0]);
    wgpr(27 + 2 * p, v[15:8]);
  endtask : wptr

  task automatic rptr(input int p, output logic [31:0] d);
    logic [31:0] lo;
    logic [31:0] hi;
    rgpr(26 + 2 * p, lo);
    rgpr(27 + 2 * p, hi);
    d = {16'h0, hi[7:0], lo[7:0]};
  endtask : rptr

  function automatic logic [31:0] mk(int op, int rd, int rr, int ps, int am, int imm);
    return {5'h00, imm[7:0], am[1:0], ps[1:0], rr[4:0], rd[4:0], op[4:0]};
  endfunction : mk

  // Execution cycles are the busy edges after the decode cycle.
  task automatic run(input logic [31:0] cmd, input int n);
    int k;
    k = 0;
    bus_wr(`CBLS_REG_CMD, cmd);
    do begin
      @(posedge sys_clk);
      k++;
    end while (busy !== 1'b0 && k < 50);
    chk("exec cycles", n, k - 1);
  endtask : run

  function automatic logic taken(int op, logic [7:0] s);
    logic c;
    case (op / 2)
      0: c = s[`CBLS_SREG_N] ^ s[`CBLS_SREG_V];
      1: c = s[`CBLS_SREG_H];
      2: c = s[`CBLS_SREG_T];
      3: c = s[`CBLS_SREG_V];
      default: c = s[`CBLS_SREG_I];
    endcase
    return c == (((op % 2) == 0) ^ (op < 2));
  endfunction : taken

  initial begin
    logic [31:0] d;
    logic [15:0] base;
    logic [15:0] a;
    logic [15:0] np;
    logic [7:0]  v;
    logic [7:0]  sv [3];
    logic        t;
    int          n;
    sv = '{8'h00, 8'h04, 8'hff};
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    bus_rd(`CBLS_REG_CMD, d);
    chk("cmd reset", `CBLS_RST_CMD, d);
    bus_rd(`CBLS_REG_PC, d);
    chk("pc reset", 32'h0, d);
    for (int op = 0; op < 10; op++) begin
      for (int i = 0; i < 3; i++) begin
        t = taken(op, sv[i]);
        bus_wr(`CBLS_REG_SREG, {24'h0, sv[i]});
        bus_wr(`CBLS_REG_PC, 32'h0100);
        run(mk(op, 0, 0, 0, 0, 8'hf0), t ? 2 : 1);
        bus_rd(`CBLS_REG_PC, d);
        chk("branch pc", t ? 32'h00f1 : 32'h0101, d);
        bus_rd(`CBLS_REG_SREG, d);
        chk("branch flags", {24'h0, sv[i]}, d);
      end
    end
    wgpr(3, 8'ha5);
    wgpr(2, 8'h5c);
    run(mk(10, 4, 3, 0, 0, 0), 1);
    rgpr(4, d);
    chk("copy", 32'ha5, d);
    run(mk(11, 6, 2, 0, 0, 0), 1);
    rgpr(6, d);
    chk("pair copy lo", 32'h5c, d);
    rgpr(7, d);
    chk("pair copy hi", 32'ha5, d);
    run(mk(12, 16, 0, 0, 0, 8'h3c), 1);
    rgpr(16, d);
    chk("constant", 32'h3c, d);
    bus_wr(`CBLS_REG_ADDR, 32'h0040);
    bus_wr(`CBLS_REG_PC, 32'h0010);
    run(mk(15, 4, 0, 0, 0, 0), 2);
    chk("store direct", 32'ha5, {24'h0, i_cbls_mem_model.mem_ff[8'h40]});
    run(mk(13, 9, 0, 0, 0, 0), 2);
    rgpr(9, d);
    chk("load direct", 32'ha5, d);
    bus_rd(`CBLS_REG_PC, d);
    chk("direct pc", 32'h0014, d);
    bus_wr(`CBLS_REG_CMD, mk(13, 9, 0, 0, 0, 0));
    bus_wr(`CBLS_REG_PC, 32'h0555);
    bus_rd(`CBLS_REG_PC, d);
    chk("write held while busy", 32'h0555, d);
    avs_byteenable <= 4'h1;
    bus_wr(`CBLS_REG_PC, 32'h0000_ffaa);
    avs_byteenable <= 4'hf;
    run(32'h0000_001f, 1);
    bus_rd(`CBLS_REG_PC, d);
    chk("pc lane merge then no-op", 32'h05ab, d);
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        v = 8'h90 ^ 8'(p * 4 + m);
        base = 16'h0080 + 16'(p * 16);
        a = (m == 2) ? base - 16'h0001 : (m == 3 && p > 0) ? base + 16'h0003 : base;
        np = (m == 1) ? base + 16'h0001 : (m == 2) ? base - 16'h0001 : base;
        n = (m == 2 || (m == 3 && p > 0)) ? 2 : 1;
        wgpr(1, v);
        wptr(p, base);
        run(mk(16, 1, 0, p, m, 3), n);
        chk("store mem", {24'h0, v}, {24'h0, i_cbls_mem_model.mem_ff[a[7:0]]});
        rptr(p, d);
        chk("store ptr", {16'h0, np}, d);
        wptr(p, base);
        run(mk(14, 2, 0, p, m, 3), n);
        rgpr(2, d);
        chk("load data", {24'h0, v}, d);
        rptr(p, d);
        chk("load ptr", {16'h0, np}, d);
      end
    end
    wptr(2, 16'h0123);
    run(mk(17, 0, 0, 0, 0, 0), 3);
    rgpr(0, d);
    chk("program load", 32'h23 ^ 32'h5a, d);
    bus_rd(`CBLS_REG_STAT, d);
    chk("stat cycles", 32'h3, {30'h0, d[5:4]});
    bus_wr(8'h40, 32'hffff_ffff);
    bus_rd(8'h40, d);
    chk("unmapped", 32'h0, d);
    end_sim();
  end
endmodule : cbls_exec_tb_top

// File: verification/cbls_mem_model.sv
// Data-space and program-memory model that answers the execution unit.
`timescale 1ns/1ps
module cbls_mem_model #(
  parameter int AW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic [AW-1:0] dmem_addr,
  input  wire logic [7:0]    dmem_wdata,
  input  wire logic          dmem_rd,
  input  wire logic          dmem_wr,
  output logic [7:0]         dmem_rdata,
  input  wire logic [AW-1:0] pmem_addr,
  input  wire logic          pmem_rd,
  output logic [7:0]         pmem_rdata
);
  logic [7:0] mem_ff [256];

  // Only the low byte of the address is decoded, so the bench keeps its data-space addresses below 0x100.
  always_ff @(posedge sys_clk) begin
    if (dmem_wr) begin
      mem_ff[dmem_addr[7:0]] <= dmem_wdata;
    end
  end

  // Outside a strobe the lines show inverted data, so a late sample cannot pass by luck.
  assign dmem_rdata = dmem_rd ? mem_ff[dmem_addr[7:0]] : ~mem_ff[dmem_addr[7:0]];
  assign pmem_rdata = pmem_rd ? (pmem_addr[7:0] ^ 8'h5a) : ~(pmem_addr[7:0] ^ 8'h5a);
endmodule : cbls_mem_model

// File: verilog/cbls_consts.svh
// Offsets, field positions, reset values and cycle counts of the execution unit.
// Summary of operation
// - Signed greater-or-equal branch: N xor V zero.
// - Signed less-than branch: N xor V one.
// - Half-carry branches on H set or clear.
// - Transfer-bit branches on T set or clear.
// - Overflow branches on V set or clear.
// - Interrupt-state branches on I set or clear.
// - Direct load reads absolute address, two cycles.
// - Direct store writes absolute address, two cycles.
// - Indirect load, plain or post-increment, one cycle.
// - Pre-decrement load: decrement, then read; two cycles.
// - Offset load from Y/Z plus q, two cycles.
// - Indirect store, plain or post-increment, one cycle.
// - Pre-decrement store: decrement, then write; two cycles.
// - Offset store to Y/Z plus q, two cycles.
`ifndef CBLS_CONSTS_SVH
`define CBLS_CONSTS_SVH

`define CBLS_REG_CMD       8'h00
`define CBLS_REG_ADDR      8'h04
`define CBLS_REG_PC        8'h08
`define CBLS_REG_SREG      8'h0c
`define CBLS_REG_STAT      8'h10
`define CBLS_REG_GPR       8'h80

`define CBLS_F_OP_MSB      4
`define CBLS_F_OP_LSB      0
`define CBLS_F_RD_MSB      9
`define CBLS_F_RD_LSB      5
`define CBLS_F_RR_MSB      14
`define CBLS_F_RR_LSB      10
`define CBLS_F_PSEL_MSB    16
`define CBLS_F_PSEL_LSB    15
`define CBLS_F_AMODE_MSB   18
`define CBLS_F_AMODE_LSB   17
`define CBLS_F_IMM_MSB     26
`define CBLS_F_IMM_LSB     19

`define CBLS_SREG_C        0
`define CBLS_SREG_Z        1
`define CBLS_SREG_N        2
`define CBLS_SREG_V        3
`define CBLS_SREG_S        4
`define CBLS_SREG_H        5
`define CBLS_SREG_T        6
`define CBLS_SREG_I        7

`define CBLS_STAT_BUSY     0
`define CBLS_STAT_CYC_LSB  4
`define CBLS_STAT_CYC_MSB  5
`define CBLS_STAT_TAKEN    8

`define CBLS_RST_PC        16'h0000
`define CBLS_RST_SREG      8'h00
`define CBLS_RST_CMD       32'h0000_001f

`define CBLS_PTR_X_LO      5'h1a
`define CBLS_PTR_Y_LO      5'h1c
`define CBLS_PTR_Z_LO      5'h1e
`define CBLS_GPR_R0        5'h00

`define CBLS_CYC_ONE       2'h1
`define CBLS_CYC_BR_TAKEN  2'h2
`define CBLS_CYC_DIRECT    2'h2
`define CBLS_CYC_PREDEC    2'h2
`define CBLS_CYC_OFFSET    2'h2
`define CBLS_CYC_PMEM      2'h3
`define CBLS_DIRECT_WORDS  2'h2

`endif

// File: verilog/cbls_exec.sv
// Branch and data-transfer execution unit with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "cbls_consts.svh"
module cbls_exec
  import cbls_pkg::*;
#(
  parameter int AW = 16,
  parameter int PW = 16
) (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic [7:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  output logic [AW-1:0]      dmem_addr,
  output logic [7:0]         dmem_wdata,
  output logic               dmem_rd,
  output logic               dmem_wr,
  input  wire logic [7:0]    dmem_rdata,
  output logic [AW-1:0]      pmem_addr,
  output logic               pmem_rd,
  input  wire logic [7:0]    pmem_rdata,
  output logic               busy
);

  logic [7:0]    gpr_ff [32];
  logic [31:0]   cmd_ff;
  logic [AW-1:0] kaddr_ff;
  logic [PW-1:0] pc_ff;
  logic [7:0]    sreg_ff;
  cbls_state_t   state_ff;
  logic [1:0]    cnt_ff;
  logic [1:0]    last_cyc_ff;
  logic          last_taken_ff;
  logic          busy_ff;
  logic          wait_ff;
  logic [31:0]   rdata_ff;
  logic [AW-1:0] dmem_addr_ff;
  logic [7:0]    dmem_wdata_ff;
  logic          dmem_rd_ff;
  logic          dmem_wr_ff;
  logic [AW-1:0] pmem_addr_ff;
  logic          pmem_rd_ff;
  logic [1:0]    run_len_ff;

  cbls_op_t      op;
  cbls_amode_t   amode;
  cbls_psel_t    psel;
  logic [4:0]    rd;
  logic [4:0]    rr;
  logic [7:0]    imm;
  logic [4:0]    ptr_lo;
  logic [AW-1:0] ptr_val;
  logic [AW-1:0] zptr;
  logic [AW-1:0] acc_addr;
  logic [AW-1:0] ptr_next;
  logic [PW-1:0] off_sx;
  logic [1:0]    ncyc;
  logic          is_br;
  logic          is_ind;
  logic          offset_ok;
  logic          taken;
  logic          prep;
  logic          fin;
  logic          bus_req;
  logic          bus_acc;
  logic          wr_acc;
  logic          launch;
  logic          gpr_hit;
  logic [31:0]   rmux;
  logic [31:0]   pc_wr;

  function automatic logic [31:0] be_merge(logic [31:0] o, logic [31:0] n, logic [3:0] be);
    be_merge = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        be_merge[8*i+:8] = n[8*i+:8];
      end
    end
  endfunction : be_merge

  function automatic logic br_cond(cbls_op_t o, logic [7:0] s);
    case (o)
      op_branch_signed_ge:          br_cond = ~(s[`CBLS_SREG_N] ^ s[`CBLS_SREG_V]);
      op_branch_signed_less:        br_cond = s[`CBLS_SREG_N] ^ s[`CBLS_SREG_V];
      op_branch_halfcarry_set:      br_cond = s[`CBLS_SREG_H];
      op_branch_halfcarry_clear:    br_cond = ~s[`CBLS_SREG_H];
      op_branch_transfer_bit_set:   br_cond = s[`CBLS_SREG_T];
      op_branch_transfer_bit_clear: br_cond = ~s[`CBLS_SREG_T];
      op_branch_overflow_set:       br_cond = s[`CBLS_SREG_V];
      op_branch_overflow_clear:     br_cond = ~s[`CBLS_SREG_V];
      op_branch_irq_on:             br_cond = s[`CBLS_SREG_I];
      op_branch_irq_off:            br_cond = ~s[`CBLS_SREG_I];
      default:                      br_cond = 1'b0;
    endcase
  endfunction : br_cond

  assign op        = cbls_op_t'(cmd_ff[`CBLS_F_OP_MSB:`CBLS_F_OP_LSB]);
  assign amode     = cbls_amode_t'(cmd_ff[`CBLS_F_AMODE_MSB:`CBLS_F_AMODE_LSB]);
  assign psel      = cbls_psel_t'(cmd_ff[`CBLS_F_PSEL_MSB:`CBLS_F_PSEL_LSB]);
  assign rd        = cmd_ff[`CBLS_F_RD_MSB:`CBLS_F_RD_LSB];
  assign rr        = cmd_ff[`CBLS_F_RR_MSB:`CBLS_F_RR_LSB];
  assign imm       = cmd_ff[`CBLS_F_IMM_MSB:`CBLS_F_IMM_LSB];
  assign off_sx    = {{(PW-8){imm[7]}}, imm};
  assign is_br     = op <= op_branch_irq_off;
  assign is_ind    = (op == op_load_indirect) || (op == op_write_indirect);
  assign offset_ok = (psel == ptr_y) || (psel == ptr_z);
  assign taken     = is_br && br_cond(op, sreg_ff);
  assign ptr_val   = AW'({gpr_ff[ptr_lo + 5'h01], gpr_ff[ptr_lo]});
  assign zptr      = AW'({gpr_ff[`CBLS_PTR_Z_LO + 5'h01], gpr_ff[`CBLS_PTR_Z_LO]});
  assign fin       = (state_ff == fsm_run) && (cnt_ff == 2'h0);
  assign prep      = ((state_ff == fsm_load) && (ncyc == `CBLS_CYC_ONE)) ||
                     ((state_ff == fsm_run) && (cnt_ff == 2'h1));

  always_comb begin
    unique case (psel)
      ptr_y:   ptr_lo = `CBLS_PTR_Y_LO;
      ptr_z:   ptr_lo = `CBLS_PTR_Z_LO;
      default: ptr_lo = `CBLS_PTR_X_LO;
    endcase
  end

  always_comb begin
    ncyc = `CBLS_CYC_ONE;
    if (taken) begin
      ncyc = `CBLS_CYC_BR_TAKEN;
    end else if (op == op_load_direct || op == op_write_direct) begin
      ncyc = `CBLS_CYC_DIRECT;
    end else if (is_ind && amode == am_pre_dec) begin
      ncyc = `CBLS_CYC_PREDEC;
    end else if (is_ind && amode == am_offset && offset_ok) begin
      ncyc = `CBLS_CYC_OFFSET;
    end else if (op == op_read_program_memory) begin
      ncyc = `CBLS_CYC_PMEM;
    end
  end

  cbls_ptr_unit #(
    .AW        (AW)
  ) i_cbls_ptr_unit (
    .ptr_val   (ptr_val),
    .amode     (amode),
    .offset_ok (offset_ok),
    .disp      (imm),
    .acc_addr  (acc_addr),
    .ptr_next  (ptr_next)
  );

  // Register slave: one wait cycle per access; writes stall while an instruction runs.
  assign bus_req = avs_read | avs_write;
  assign bus_acc = bus_req & ~wait_ff;
  assign wr_acc  = bus_acc & avs_write;
  assign launch  = wr_acc && (avs_address == `CBLS_REG_CMD);
  assign gpr_hit = avs_address >= `CBLS_REG_GPR;
  assign pc_wr   = be_merge({{(32-PW){1'b0}}, pc_ff}, avs_writedata, avs_byteenable);

  always_comb begin
    rmux = 32'h0000_0000;
    if (gpr_hit) begin
      rmux = {24'h00_0000, gpr_ff[avs_address[6:2]]};
    end else begin
      case (avs_address)
        `CBLS_REG_CMD:  rmux = cmd_ff;
        `CBLS_REG_ADDR: rmux = {{(32-AW){1'b0}}, kaddr_ff};
        `CBLS_REG_PC:   rmux = {{(32-PW){1'b0}}, pc_ff};
        `CBLS_REG_SREG: rmux = {24'h00_0000, sreg_ff};
        `CBLS_REG_STAT: begin
          rmux[`CBLS_STAT_BUSY]                        = busy_ff;
          rmux[`CBLS_STAT_CYC_MSB:`CBLS_STAT_CYC_LSB]  = last_cyc_ff;
          rmux[`CBLS_STAT_TAKEN]                       = last_taken_ff;
        end
        default:        rmux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff <= ~(bus_req && wait_ff && (avs_read || state_ff == fsm_idle));
      if (bus_req && wait_ff && avs_read) begin
        rdata_ff <= rmux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_ff   <= `CBLS_RST_CMD;
      kaddr_ff <= {AW{1'b0}};
      sreg_ff  <= `CBLS_RST_SREG;
    end else if (wr_acc) begin
      // Flags are written only by software; no instruction here alters them.
      if (avs_address == `CBLS_REG_CMD) begin
        cmd_ff <= be_merge(cmd_ff, avs_writedata, avs_byteenable);
      end
      if (avs_address == `CBLS_REG_ADDR) begin
        kaddr_ff <= AW'(be_merge({{(32-AW){1'b0}}, kaddr_ff}, avs_writedata, avs_byteenable));
      end
      if (avs_address == `CBLS_REG_SREG && avs_byteenable[0]) begin
        sreg_ff <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= fsm_idle;
      cnt_ff   <= 2'h0;
    end else begin
      unique case (state_ff)
        fsm_idle: begin
          if (launch) begin
            state_ff <= fsm_load;
          end
        end
        fsm_load: begin
          state_ff <= fsm_run;
          cnt_ff   <= ncyc - 2'h1;
        end
        fsm_run: begin
          if (cnt_ff == 2'h0) begin
            state_ff <= fsm_idle;
          end else begin
            cnt_ff <= cnt_ff - 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy_ff       <= 1'b0;
      last_cyc_ff   <= 2'h0;
      last_taken_ff <= 1'b0;
    end else if (launch) begin
      busy_ff <= 1'b1;
    end else if (state_ff == fsm_load) begin
      last_cyc_ff   <= ncyc;
      last_taken_ff <= taken;
    end else if (fin) begin
      busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pc_ff <= PW'(`CBLS_RST_PC);
    end else if (wr_acc && avs_address == `CBLS_REG_PC) begin
      pc_ff <= pc_wr[PW-1:0];
    end else if (fin) begin
      if (taken) begin
        pc_ff <= pc_ff + off_sx + PW'(1);
      end else if (op == op_load_direct || op == op_write_direct) begin
        pc_ff <= pc_ff + PW'(`CBLS_DIRECT_WORDS);
      end else begin
        pc_ff <= pc_ff + PW'(1);
      end
    end
  end

  // Strobes stand for exactly the last execution cycle; the partner memory reads without delay.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dmem_addr_ff  <= {AW{1'b0}};
      dmem_wdata_ff <= 8'h00;
      dmem_rd_ff    <= 1'b0;
      dmem_wr_ff    <= 1'b0;
      pmem_addr_ff  <= {AW{1'b0}};
      pmem_rd_ff    <= 1'b0;
    end else if (prep) begin
      dmem_rd_ff    <= (op == op_load_direct) || (op == op_load_indirect);
      dmem_wr_ff    <= (op == op_write_direct) || (op == op_write_indirect);
      dmem_addr_ff  <= is_ind ? acc_addr : kaddr_ff;
      dmem_wdata_ff <= gpr_ff[rd];
      pmem_rd_ff    <= op == op_read_program_memory;
      pmem_addr_ff  <= zptr;
    end else if (fin) begin
      dmem_rd_ff <= 1'b0;
      dmem_wr_ff <= 1'b0;
      pmem_rd_ff <= 1'b0;
    end
  end

  // A post-increment update falls after the destination write in the same cycle, so it wins on overlap; a pre-decrement lands a cycle earlier and loses.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        gpr_ff[i] <= 8'h00;
      end
    end else begin
      if (wr_acc && gpr_hit && avs_byteenable[0]) begin
        gpr_ff[avs_address[6:2]] <= avs_writedata[7:0];
      end
      if (fin) begin
        case (op)
          op_copy_register:       gpr_ff[rd] <= gpr_ff[rr];
          op_copy_register_word: begin
            gpr_ff[{rd[4:1], 1'b0}] <= gpr_ff[{rr[4:1], 1'b0}];
            gpr_ff[{rd[4:1], 1'b1}] <= gpr_ff[{rr[4:1], 1'b1}];
          end
          op_load_constant:       gpr_ff[rd] <= imm;
          op_load_direct:         gpr_ff[rd] <= dmem_rdata;
          op_load_indirect:       gpr_ff[rd] <= dmem_rdata;
          op_read_program_memory: gpr_ff[`CBLS_GPR_R0] <= pmem_rdata;
          default: begin
          end
        endcase
      end
      if (is_ind && ((prep && amode == am_pre_dec) || (fin && amode == am_post_inc))) begin
        {gpr_ff[ptr_lo + 5'h01], gpr_ff[ptr_lo]} <= 16'(ptr_next);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_len_ff <= 2'h0;
    end else if (state_ff == fsm_load) begin
      run_len_ff <= 2'h0;
    end else if (state_ff == fsm_run) begin
      run_len_ff <= run_len_ff + 2'h1;
    end
  end

  assign avs_readdata    = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign dmem_addr       = dmem_addr_ff;
  assign dmem_wdata      = dmem_wdata_ff;
  assign dmem_rd         = dmem_rd_ff;
  assign dmem_wr         = dmem_wr_ff;
  assign pmem_addr       = pmem_addr_ff;
  assign pmem_rd         = pmem_rd_ff;
  assign busy            = busy_ff;

  br_ge_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_branch_signed_ge && sreg_ff[2] == sreg_ff[3] |-> run_len_ff == 2'h1
    ##1 pc_ff == $past(pc_ff) + off_sx + PW'(1)) else $error("ge branch wrong");
  br_lt_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_branch_signed_less && sreg_ff[2] != sreg_ff[3] |-> run_len_ff == 2'h1
    ##1 pc_ff == $past(pc_ff) + off_sx + PW'(1)) else $error("lt branch wrong");
  br_not_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && is_br && !taken |-> run_len_ff == 2'h0 ##1 pc_ff == $past(pc_ff) + PW'(1))
    else $error("untaken branch wrong");
  flag_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    busy_ff |=> $stable(sreg_ff)) else $error("flags changed");
  br_v_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_branch_overflow_set && sreg_ff[3] |-> run_len_ff == 2'h1
    ##1 pc_ff == $past(pc_ff) + off_sx + PW'(1)) else $error("v branch wrong");
  br_irq_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_branch_irq_off && !sreg_ff[7] |-> run_len_ff == 2'h1
    ##1 pc_ff == $past(pc_ff) + off_sx + PW'(1)) else $error("irq branch wrong");
  load_direct_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_load_direct |-> dmem_rd && dmem_addr == kaddr_ff && run_len_ff == 2'h1
    ##1 gpr_ff[rd] == $past(dmem_rdata)) else $error("direct load wrong");
  write_direct_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_write_direct |-> dmem_wr && dmem_addr == kaddr_ff
    && dmem_wdata == gpr_ff[rd] && run_len_ff == 2'h1) else $error("direct store wrong");
  load_post_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_load_indirect && amode == am_post_inc |-> dmem_rd && dmem_addr == ptr_val
    && run_len_ff == 2'h0 ##1 ptr_val == $past(ptr_val) + AW'(1)) else $error("load post wrong");
  load_pre_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    state_ff == fsm_load && op == op_load_indirect && amode == am_pre_dec |-> ##2 fin
    && dmem_rd && dmem_addr == ptr_val && ptr_val == $past(ptr_val, 2) - AW'(1))
    else $error("load pre wrong");
  load_offset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_load_indirect && amode == am_offset && offset_ok |-> dmem_rd
    && dmem_addr == ptr_val + AW'(imm) && run_len_ff == 2'h1 ##1 $stable(ptr_val))
    else $error("load offset wrong");
  write_post_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_write_indirect && amode == am_post_inc |-> dmem_wr && dmem_addr == ptr_val
    && run_len_ff == 2'h0 ##1 ptr_val == $past(ptr_val) + AW'(1)) else $error("store post wrong");
  write_pre_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_write_indirect && amode == am_pre_dec |-> dmem_wr && dmem_addr == ptr_val
    && run_len_ff == 2'h1 && ptr_val == $past(ptr_val, 2) - AW'(1)) else $error("store pre wrong");
  write_offset_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_write_indirect && amode == am_offset && offset_ok |-> dmem_wr
    && dmem_addr == ptr_val + AW'(imm) && run_len_ff == 2'h1 ##1 $stable(ptr_val))
    else $error("store offset wrong");
  copy_reg_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && (op == op_copy_register || op == op_load_constant) |-> run_len_ff == 2'h0
    ##1 gpr_ff[rd] == (op == op_load_constant ? imm : $past(gpr_ff[rr])))
    else $error("copy wrong");
  pmem_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    fin && op == op_read_program_memory |-> pmem_rd && pmem_addr == zptr
    && run_len_ff == 2'h2 ##1 gpr_ff[0] == $past(pmem_rdata)) else $error("pmem load wrong");

endmodule : cbls_exec

// File: verilog/cbls_pkg.sv
// Types shared by the execution unit and its pointer arithmetic.
package cbls_pkg;

  typedef enum logic [4:0] {
    op_branch_signed_ge,
    op_branch_signed_less,
    op_branch_halfcarry_set,
    op_branch_halfcarry_clear,
    op_branch_transfer_bit_set,
    op_branch_transfer_bit_clear,
    op_branch_overflow_set,
    op_branch_overflow_clear,
    op_branch_irq_on,
    op_branch_irq_off,
    op_copy_register,
    op_copy_register_word,
    op_load_constant,
    op_load_direct,
    op_load_indirect,
    op_write_direct,
    op_write_indirect,
    op_read_program_memory
  } cbls_op_t;

  typedef enum logic [1:0] {
    am_plain,
    am_post_inc,
    am_pre_dec,
    am_offset
  } cbls_amode_t;

  typedef enum logic [1:0] {
    ptr_x,
    ptr_y,
    ptr_z
  } cbls_psel_t;

  typedef enum logic [1:0] {
    fsm_idle,
    fsm_load,
    fsm_run
  } cbls_state_t;

endpackage : cbls_pkg

// File: verilog/cbls_ptr_unit.sv
// Address and pointer update arithmetic for indirect data-space accesses.
`timescale 1ns/1ps
module cbls_ptr_unit
  import cbls_pkg::*;
#(
  parameter int AW = 16
) (
  input  wire logic [AW-1:0] ptr_val,
  input  wire cbls_amode_t   amode,
  input  wire logic          offset_ok,
  input  wire logic [7:0]    disp,
  output logic [AW-1:0]      acc_addr,
  output logic [AW-1:0]      ptr_next
);

  always_comb begin
    acc_addr = ptr_val;
    ptr_next = ptr_val;
    unique case (amode)
      am_plain: begin
      end
      am_post_inc: begin
        ptr_next = ptr_val + {{(AW-1){1'b0}}, 1'b1};
      end
      am_pre_dec: begin
        ptr_next = ptr_val - {{(AW-1){1'b0}}, 1'b1};
        acc_addr = ptr_next;
      end
      am_offset: begin
        // The pointer with the first pair has no offset form; it falls back to plain.
        if (offset_ok) begin
          acc_addr = ptr_val + {{(AW-8){1'b0}}, disp};
        end
      end
    endcase
  end

endmodule : cbls_ptr_unit
